// ---- design/uart_pkg.sv ----
// Purpose: Shared constants and types for the serial transceiver core.
// Assumes: Classic Wishbone slave with 32-bit data; registers sit in byte lane 0.
// Notes: Offsets are byte addresses of aligned words.
package uart_pkg;
   localparam logic [4:0] ADR_DATA = 5'h00;
   localparam logic [4:0] ADR_STATUS = 5'h04;
   localparam logic [4:0] ADR_CONTROL = 5'h08;
   localparam logic [4:0] ADR_FORMAT = 5'h0C;
   localparam logic [4:0] ADR_BAUD = 5'h10;
   // Status register bit positions.
   localparam int ST_RXC = 7;
   localparam int ST_TXC = 6;
   localparam int ST_UDRE = 5;
   localparam int ST_FE = 4;
   localparam int ST_DOR = 3;
   localparam int ST_UPE = 2;
   // Control register bit positions.
   localparam int CT_TXCIE = 6;
   localparam int CT_UDRIE = 5;
   localparam int CT_RXEN = 4;
   localparam int CT_TXEN = 3;
   localparam int CT_RXB8 = 1;
   localparam int CT_TXB8 = 0;
   // Format register bit positions; the size code occupies bits 2:0.
   localparam int FM_SYNC = 6;
   localparam int FM_PEN = 5;
   localparam int FM_PODD = 4;
   localparam int FM_STOP2 = 3;
   localparam logic [7:0] CONTROL_RST = 8'h00;
   localparam logic [7:0] FORMAT_RST = 8'h03;
   localparam logic [7:0] BAUD_RST = 8'h0C;
   localparam logic [2:0] SIZE_NINE = 3'h7;
   localparam logic [3:0] BITS_MIN = 4'h5;
   localparam logic [3:0] BITS_BYTE = 4'h8;
   localparam logic [3:0] BITS_NINE = 4'h9;
   // Sixteen samples per bit; the majority vote uses samples 8, 9 and 10.
   localparam logic [3:0] SAMPLE_LAST = 4'hF;
   localparam logic [3:0] SAMPLE_VOTE = 4'hA;
   localparam logic [3:0] SAMPLE_AFTER_START = 4'h2;
   localparam logic [1:0] RX_DEPTH = 2'h2;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_START = 3'b001,
      S_DATA = 3'b011,
      S_PAR = 3'b010,
      S_STOP = 3'b110
   } frame_state_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [4:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_t;

   typedef struct packed {
      logic ninth;
      logic fe;
      logic dor;
      logic upe;
      logic [7:0] data;
   } rx_entry_t;
endpackage : uart_pkg

// ---- design/pin_sync3.sv ----
// Purpose: Three-stage synchroniser for the receive-data and transfer-clock pins.
// Assumes: Both pins idle high.
// Notes: A change is accepted only once stages two and three agree.
`timescale 1ns/1ns
module pin_sync3 (
   input logic clk_i,
   input logic rst_i,
   input logic [1:0] pin_i,
   output logic [1:0] level_o
);
   logic [1:0] s1_q;
   logic [1:0] s2_q;
   logic [1:0] s3_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_q <= 2'h3;
         s2_q <= 2'h3;
         s3_q <= 2'h3;
         level_o <= 2'h3;
      end else begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         level_o <= (s2_q & ~(s2_q ^ s3_q)) | (level_o & (s2_q ^ s3_q));
      end
   end
endmodule : pin_sync3

// ---- design/uart_core.sv ----
// Purpose: Serial transceiver core with transmit flags, parity and a buffered receiver.
// Assumes: Classic Wishbone slave; one clock; global interrupt masking lies outside.
// Notes: Receive buffer holds two frames plus one frame waiting in a separate hold register.
//
// Local design decisions: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
module uart_core (
   input logic clk_i,
   input logic rst_i,
   input uart_pkg::wb_req_t wb_i,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   output logic txd_o,
   output logic txd_oe_o,
   input logic rxd_i,
   output logic rxd_override_o,
   input logic xck_i,
   output logic tx_empty_irq_o,
   output logic tx_complete_irq_o,
   input logic tx_complete_ack_i
);
   import uart_pkg::*;

   logic [7:0] control_q;
   logic [7:0] format_q;
   logic [7:0] baud_q;
   logic [7:0] baud_cnt_q;
   logic ack_q;
   logic [31:0] dat_q;
   logic [1:0] pin_lvl;
   logic xck_prev_q;

   // Bus decode. A write takes effect on the edge where the master sees ack.
   wire req = wb_i.cyc && wb_i.stb;
   wire wr_ev = req && wb_i.we && wb_i.sel[0] && ack_q;
   wire rd_ev = req && !wb_i.we && ack_q;
   wire [7:0] wr_byte = wb_i.dat[7:0];
   wire wr_data = wr_ev && (wb_i.adr == ADR_DATA);
   wire wr_status = wr_ev && (wb_i.adr == ADR_STATUS);
   wire wr_control = wr_ev && (wb_i.adr == ADR_CONTROL);
   wire wr_format = wr_ev && (wb_i.adr == ADR_FORMAT);
   wire wr_baud = wr_ev && (wb_i.adr == ADR_BAUD);
   wire rd_data = rd_ev && (wb_i.adr == ADR_DATA);

   wire tx_complete_irq_en = control_q[CT_TXCIE];
   wire tx_buffer_empty_irq_en = control_q[CT_UDRIE];
   wire receiver_enable = control_q[CT_RXEN];
   wire transmitter_enable = control_q[CT_TXEN];
   wire tx_ninth_bit = control_q[CT_TXB8];
   wire [2:0] char_size_code = format_q[2:0];
   wire sync_mode = format_q[FM_SYNC];
   wire parity_enable_bit = format_q[FM_PEN];
   wire parity_odd_select = format_q[FM_PODD];
   wire stop_two = format_q[FM_STOP2];

   // Reserved size codes fall back to eight bits.
   wire [3:0] n_bits = (char_size_code == SIZE_NINE) ? BITS_NINE :
      (char_size_code[2] ? BITS_BYTE : BITS_MIN + {2'b00, char_size_code[1:0]});
   wire [8:0] char_mask = 9'h1FF >> (BITS_NINE - n_bits);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         control_q <= CONTROL_RST;
         format_q <= FORMAT_RST;
         baud_q <= BAUD_RST;
      end else begin
         if (wr_control) control_q <= wr_byte;
         if (wr_format) format_q <= wr_byte;
         if (wr_baud) baud_q <= wr_byte;
      end
   end

   // Oversampling tick: sixteen per bit time in asynchronous mode.
   wire tick = (baud_cnt_q == 8'h00);

   always_ff @(posedge clk_i) begin
      if (rst_i) baud_cnt_q <= 8'h00;
      else baud_cnt_q <= tick ? baud_q : baud_cnt_q - 8'h01;
   end

   pin_sync3 u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i({xck_i, rxd_i}),
      .level_o(pin_lvl)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) xck_prev_q <= 1'b1;
      else xck_prev_q <= pin_lvl[1];
   end

   wire xck_rise = pin_lvl[1] && !xck_prev_q;
   wire xck_fall = !pin_lvl[1] && xck_prev_q;

   // ---------------- Transmitter ----------------
   frame_state_t tx_st_q;
   frame_state_t tx_st_d;
   logic [3:0] tx_sc_q;
   logic [3:0] tx_cnt_q;
   logic [8:0] tx_buf_q;
   logic [8:0] tx_sh_q;
   logic tx_full_q;
   logic tx_par_q;
   logic tx_stop2_q;
   logic tx_active_q;
   logic txc_q;
   logic txd_d;
   logic txd_q;

   // Output changes on the falling transfer clock so the far end samples on the rise.
   wire tx_tick = sync_mode ? xck_fall : (tick && tx_sc_q == SAMPLE_LAST);
   wire tx_last_stop = (tx_st_q == S_STOP) && tx_tick && (!stop_two || tx_stop2_q);
   wire tx_load = tx_full_q && tx_active_q && ((tx_st_q == S_IDLE) || tx_last_stop);
   wire tx_parity = (^(tx_buf_q & char_mask)) ^ parity_odd_select;
   wire txc_set = tx_last_stop && !tx_full_q;
   wire txc_clr = tx_complete_ack_i || (wr_status && wr_byte[ST_TXC]);

   always_comb begin
      tx_st_d = tx_st_q;
      case (tx_st_q)
         S_IDLE: if (tx_load) tx_st_d = S_START;
         S_START: if (tx_tick) tx_st_d = S_DATA;
         S_DATA: if (tx_tick && tx_cnt_q == n_bits - 4'h1) begin
            tx_st_d = parity_enable_bit ? S_PAR : S_STOP;
         end
         S_PAR: if (tx_tick) tx_st_d = S_STOP;
         S_STOP: if (tx_last_stop) tx_st_d = tx_load ? S_START : S_IDLE;
         default: tx_st_d = S_IDLE;
      endcase
   end

   always_comb begin
      case (tx_st_q)
         S_START: txd_d = 1'b0;
         S_DATA: txd_d = tx_sh_q[0];
         S_PAR: txd_d = tx_par_q;
         default: txd_d = 1'b1;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_st_q <= S_IDLE;
         tx_sc_q <= 4'h0;
         tx_cnt_q <= 4'h0;
         tx_sh_q <= 9'h1FF;
         tx_par_q <= 1'b0;
         tx_stop2_q <= 1'b0;
         txd_q <= 1'b1;
      end else begin
         tx_st_q <= tx_st_d;
         tx_sc_q <= tx_load ? 4'h0 : tx_sc_q + {3'h0, tick};
         txd_q <= txd_d;
         tx_stop2_q <= (tx_st_q == S_STOP) && (tx_stop2_q || tx_tick) && !tx_last_stop;
         if (tx_load) begin
            tx_sh_q <= tx_buf_q;
            tx_par_q <= tx_parity;
         end else if (tx_st_q == S_DATA && tx_tick) begin
            tx_sh_q <= {1'b1, tx_sh_q[8:1]};
         end
         if (tx_st_q != S_DATA) tx_cnt_q <= 4'h0;
         else if (tx_tick) tx_cnt_q <= tx_cnt_q + 4'h1;
      end
   end

   // A write on the same edge as a load refills the buffer after the move.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_buf_q <= 9'h000;
         tx_full_q <= 1'b0;
         txc_q <= 1'b0;
         tx_active_q <= 1'b0;
      end else begin
         if (wr_data) tx_buf_q <= {tx_ninth_bit, wr_byte};
         tx_full_q <= wr_data || (tx_full_q && !tx_load);
         txc_q <= txc_set || (txc_q && !txc_clr);
         if (transmitter_enable) tx_active_q <= 1'b1;
         else if (tx_st_q == S_IDLE && !tx_full_q) tx_active_q <= 1'b0;
      end
   end

   assign txd_o = txd_q;
   assign txd_oe_o = tx_active_q;
   assign tx_empty_irq_o = tx_buffer_empty_irq_en && !tx_full_q;
   assign tx_complete_irq_o = tx_complete_irq_en && txc_q;

   a_write_fills_buffer: assert property (
      @(posedge clk_i) disable iff (rst_i) wr_data |=> tx_full_q)
      else $error("Data write did not mark the transmit buffer full.");
   a_flag_tracks_move: assert property (
      @(posedge clk_i) disable iff (rst_i) $fell(tx_full_q) |-> $past(tx_load))
      else $error("Transmit buffer emptied without a move to the shifter.");
   a_empty_request_drop: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (tx_empty_irq_o && wr_data) |=> !tx_empty_irq_o)
      else $error("Buffer-empty request stayed high after a data write.");
   a_complete_cause: assert property (
      @(posedge clk_i) disable iff (rst_i)
      $rose(txc_q) |-> $past(tx_st_q == S_STOP && !tx_full_q))
      else $error("Transmit-complete set outside the final stop bit.");
   a_complete_service: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (tx_complete_ack_i && !txc_set) |=> !tx_complete_irq_o)
      else $error("Transmit-complete request survived its service.");
   a_parity_on_pin: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (tx_st_q == S_PAR) |=> (txd_o == $past(tx_par_q)))
      else $error("Parity bit not driven during the parity slot.");
   a_disable_deferred: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (tx_st_q != S_IDLE || (tx_full_q && tx_active_q)) |=> txd_oe_o)
      else $error("Transmitter released the pin with data still to send.");
   a_pin_released: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (!transmitter_enable && tx_st_q == S_IDLE && !tx_full_q) |=> !txd_oe_o)
      else $error("Idle disabled transmitter still overrides the pin.");
   a_idle_line_high: assert property (
      @(posedge clk_i) disable iff (rst_i) (tx_st_q == S_IDLE) |=> txd_o)
      else $error("Transmit line not high while idle.");

   // ---------------- Receiver ----------------
   frame_state_t rx_st_q;
   frame_state_t rx_st_d;
   logic [3:0] rx_sc_q;
   logic [3:0] rx_cnt_q;
   logic [2:0] rx_maj_q;
   logic [8:0] rx_sh_q;
   logic rx_pbit_q;
   rx_entry_t fifo_q [RX_DEPTH];
   logic rd_ptr_q;
   logic wr_ptr_q;
   logic [1:0] count_q;
   rx_entry_t hold_q;
   logic hold_v_q;
   logic dor_pend_q;
   rx_entry_t rx_new;
   rx_entry_t push_val;

   wire rx_bit = pin_lvl[0];
   wire [2:0] maj_now = {rx_maj_q[1:0], rx_bit};
   wire rx_vote = (maj_now[0] & maj_now[1]) | (maj_now[1] & maj_now[2]) |
      (maj_now[0] & maj_now[2]);
   wire rx_eval = sync_mode ? xck_rise : (tick && rx_sc_q == SAMPLE_VOTE);
   wire rx_val = sync_mode ? rx_bit : rx_vote;
   wire rx_start_det = receiver_enable && (rx_st_q == S_IDLE) && !rx_bit &&
      (sync_mode ? xck_rise : tick);
   wire rx_done = receiver_enable && (rx_st_q == S_STOP) && rx_eval;
   // Data shifts in LSB first, so a short character ends up in the high bits.
   wire [8:0] rx_word = rx_sh_q >> (BITS_NINE - n_bits);
   wire rx_upe = parity_enable_bit && (((^rx_word) ^ parity_odd_select) != rx_pbit_q);
   wire fifo_full = (count_q == RX_DEPTH);
   wire pop = rd_data && (count_q != 2'h0);
   wire push_hold = hold_v_q && (!fifo_full || pop);
   wire push = push_hold || (rx_done && !hold_v_q && (!fifo_full || pop));
   wire rx_to_hold = rx_done && (hold_v_q ? push_hold : !push);
   wire dor_set = (rx_start_det && hold_v_q && fifo_full) || (rx_done && !push && !rx_to_hold);
   rx_entry_t head;
   assign head = fifo_q[rd_ptr_q];

   assign rx_new = {rx_word[8], !rx_val, 1'b0, rx_upe, rx_word[7:0]};

   // Overrun marks the first frame stored after the loss.
   always_comb begin
      push_val = push_hold ? hold_q : rx_new;
      push_val.dor = dor_pend_q;
   end

   always_comb begin
      rx_st_d = rx_st_q;
      case (rx_st_q)
         S_IDLE: if (rx_start_det) rx_st_d = sync_mode ? S_DATA : S_START;
         S_START: if (rx_eval) rx_st_d = rx_val ? S_IDLE : S_DATA;
         S_DATA: if (rx_eval && rx_cnt_q == n_bits - 4'h1) begin
            rx_st_d = parity_enable_bit ? S_PAR : S_STOP;
         end
         S_PAR: if (rx_eval) rx_st_d = S_STOP;
         S_STOP: if (rx_eval) rx_st_d = S_IDLE;
         default: rx_st_d = S_IDLE;
      endcase
      if (!receiver_enable) rx_st_d = S_IDLE;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_st_q <= S_IDLE;
         rx_sc_q <= 4'h0;
         rx_cnt_q <= 4'h0;
         rx_maj_q <= 3'h7;
         rx_sh_q <= 9'h000;
         rx_pbit_q <= 1'b0;
      end else begin
         rx_st_q <= rx_st_d;
         rx_sc_q <= rx_start_det ? SAMPLE_AFTER_START : rx_sc_q + {3'h0, tick};
         if (tick) rx_maj_q <= maj_now;
         if (rx_st_q == S_DATA && rx_eval) rx_sh_q <= {rx_val, rx_sh_q[8:1]};
         if (rx_st_q == S_PAR && rx_eval) rx_pbit_q <= rx_val;
         if (rx_st_q != S_DATA) rx_cnt_q <= 4'h0;
         else if (rx_eval) rx_cnt_q <= rx_cnt_q + 4'h1;
      end
   end

   // Disabling the receiver flushes the buffer and any waiting frame.
   always_ff @(posedge clk_i) begin
      if (rst_i || !receiver_enable) begin
         rd_ptr_q <= 1'b0;
         wr_ptr_q <= 1'b0;
         count_q <= 2'h0;
         hold_v_q <= 1'b0;
         hold_q <= '0;
         dor_pend_q <= 1'b0;
      end else begin
         count_q <= count_q + {1'b0, push} - {1'b0, pop};
         if (push) wr_ptr_q <= !wr_ptr_q;
         if (pop) rd_ptr_q <= !rd_ptr_q;
         if (rx_to_hold) hold_q <= rx_new;
         hold_v_q <= rx_to_hold || (hold_v_q && !push_hold);
         dor_pend_q <= dor_set || (dor_pend_q && !push);
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < RX_DEPTH; gi++) begin : g_entry
         always_ff @(posedge clk_i) begin
            if (rst_i) fifo_q[gi] <= '0;
            else if (push && wr_ptr_q == gi) fifo_q[gi] <= push_val;
         end
      end
   endgenerate

   a_start_validated: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (rx_st_q == S_START && rx_eval && rx_val) |=> (rx_st_q == S_IDLE))
      else $error("Rejected start bit still began a frame.");
   a_single_stop: assert property (
      @(posedge clk_i) disable iff (rst_i) rx_done |=> (rx_st_q == S_IDLE))
      else $error("Receiver waited for a second stop bit.");
   a_frame_buffered: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (rx_done && !hold_v_q && count_q == 2'h0) |=> (count_q == 2'h1))
      else $error("Received frame not moved into the buffer.");
   a_flush_on_disable: assert property (
      @(posedge clk_i) disable iff (rst_i) !receiver_enable |=> (count_q == 2'h0))
      else $error("Receive buffer not flushed when disabled.");

   // ---------------- Register read ----------------
   logic [7:0] status_rd;
   logic [7:0] control_rd;
   logic [7:0] rd_mux;

   always_comb begin
      status_rd = 8'h00;
      status_rd[ST_RXC] = (count_q != 2'h0);
      status_rd[ST_TXC] = txc_q;
      status_rd[ST_UDRE] = !tx_full_q;
      status_rd[ST_FE] = head.fe && (count_q != 2'h0);
      status_rd[ST_DOR] = head.dor && (count_q != 2'h0);
      status_rd[ST_UPE] = head.upe && (count_q != 2'h0);
      control_rd = control_q;
      control_rd[CT_RXB8] = head.ninth && (count_q != 2'h0);
      case (wb_i.adr)
         ADR_DATA: rd_mux = (count_q != 2'h0) ? head.data : 8'h00;
         ADR_STATUS: rd_mux = status_rd;
         ADR_CONTROL: rd_mux = control_rd;
         ADR_FORMAT: rd_mux = format_q;
         ADR_BAUD: rd_mux = baud_q;
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else begin
         ack_q <= req && !ack_q;
         if (req && !ack_q) dat_q <= {24'h00_0000, rd_mux};
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign rxd_override_o = receiver_enable;
endmodule : uart_core

// ---- verification/serial_peer.sv ----
// Purpose: Remote serial peer that drives the receive pin and captures transmit frames.
// Assumes: Baud divisor 0, so an asynchronous bit lasts 16 clocks; a synchronous bit too.
// Notes: The line idles high; frames are sent whole, start bit first.
`timescale 1ns/1ns
module serial_peer (
   input wire logic clk_i,
   input wire logic txd_i,
   output logic rxd_o,
   output logic xck_o
);
   initial rxd_o = 1'b1;
   initial xck_o = 1'b1;
   task automatic put(input logic b);
      rxd_o <= b;
      repeat (16) @(posedge clk_i);
   endtask : put
   // Start low, data LSB first, optional parity, one stop, then idle high.
   task automatic send(input logic [8:0] d, input int n, input logic pen, input logic pb,
      input logic stop);
      int i;
      put(1'b0);
      for (i = 0; i < n; i++) put(d[i]);
      if (pen) put(pb);
      put(stop);
      put(1'b1);
   endtask : send
   // Data changes with the falling transfer clock; the clock rests high between frames,
   // so the receiver sees no stray rising edge outside a frame.
   task automatic put_sync(input logic b);
      rxd_o <= b;
      xck_o <= 1'b0;
      repeat (8) @(posedge clk_i);
      xck_o <= 1'b1;
      repeat (8) @(posedge clk_i);
   endtask : put_sync
   task automatic send_sync(input logic [8:0] d, input int n);
      int i;
      put_sync(1'b0);
      for (i = 0; i < n; i++) put_sync(d[i]);
      put_sync(1'b1);
      repeat (8) @(posedge clk_i);
   endtask : send_sync
   // Samples mid-bit; bit 0 of the result is the start bit. It returns in the middle of
   // the last bit, so the start edge of a back-to-back frame is not missed.
   task automatic recv(input int n, output logic [11:0] bits);
      int i;
      bits = '0;
      while (txd_i !== 1'b0) @(negedge clk_i);
      repeat (8) @(negedge clk_i);
      for (i = 0; i <= n; i++) begin
         bits[i] = txd_i;
         if (i < n) repeat (16) @(negedge clk_i);
      end
   endtask : recv
endmodule : serial_peer

// ---- verification/uart_core_test.sv ----
// Purpose: Self-checking bench for the serial transceiver core.
// Assumes: Baud divisor 0 gives 16 clocks a bit; the peer drives the transfer clock pin.
// Notes: The bus task samples ack at the rising edge and releases the request on that edge.
`timescale 1ns/1ns
module uart_core_test;
   import uart_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   wb_req_t wb = '0;
   logic wb_ack_o, txd_o, txd_oe_o, rxd, rxd_override_o, txe_irq, txc_irq, ext_transfer_clock_pin;
   logic txc_ack = 1'b0;
   logic [31:0] wb_dat_o;
   logic [11:0] f1, f2;
   int fail_count = 0;
   int checked = 0;
   int cycles = 0;
   always #25 clk_i = ~clk_i;
   uart_core uart_core_i (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_ack_o(wb_ack_o),
      .wb_dat_o(wb_dat_o), .txd_o(txd_o), .txd_oe_o(txd_oe_o), .rxd_i(rxd),
      .rxd_override_o(rxd_override_o), .xck_i(ext_transfer_clock_pin), .tx_empty_irq_o(txe_irq),
      .tx_complete_irq_o(txc_irq), .tx_complete_ack_i(txc_ack));
   serial_peer serial_peer_i (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd), .xck_o(ext_transfer_clock_pin));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check
   task automatic bus(input logic we, input logic [4:0] a, input logic [7:0] d,
      output logic [31:0] r);
      wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'h1, dat: {24'h00_0000, d}};
      // Ack and read data are seen as they stood at the edge, before its updates land.
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      r = wb_dat_o;
      wb <= '0;
      @(posedge clk_i);
   endtask : bus
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask : wr
   task automatic rd(input logic [4:0] a, input logic [7:0] exp);
      logic [31:0] r;
      bus(1'b0, a, 8'h00, r);
      check(r, {24'h00_0000, exp});
   endtask : rd
   task automatic t_reset;
      check({txd_o, txd_oe_o, rxd_override_o, txe_irq, txc_irq}, 5'h10);
      rd(ADR_STATUS, 8'h20);
      rd(ADR_CONTROL, CONTROL_RST);
      rd(ADR_FORMAT, FORMAT_RST);
      rd(ADR_BAUD, BAUD_RST);
      rd(5'h14, 8'h00);
      wr(ADR_BAUD, 8'h00);
      $display("test reset done");
   endtask : t_reset
   task automatic t_tx_parity;
      wr(ADR_FORMAT, 8'h33);
      wr(ADR_STATUS, 8'h00);
      wr(ADR_DATA, 8'hA5);
      rd(ADR_STATUS, 8'h00);
      wr(ADR_CONTROL, 8'h60);
      check(txe_irq, 1'b0);
      fork
         serial_peer_i.recv(10, f1);
         wr(ADR_CONTROL, 8'h68);
      join
      check(f1, {2'b11, 8'hA5, 1'b0});
      repeat (16) @(posedge clk_i);
      check({txe_irq, txc_irq}, 2'b11);
      rd(ADR_STATUS, 8'h60);
      txc_ack <= 1'b1;
      @(posedge clk_i);
      txc_ack <= 1'b0;
      @(posedge clk_i);
      check(txc_irq, 1'b0);
      $display("test tx parity done");
   endtask : t_tx_parity
   task automatic t_tx_disable;
      wr(ADR_FORMAT, 8'h03);
      fork
         begin
            serial_peer_i.recv(9, f1);
            serial_peer_i.recv(9, f2);
         end
         begin
            wr(ADR_DATA, 8'h3C);
            wr(ADR_DATA, 8'h5A);
            wr(ADR_CONTROL, 8'h00);
            check(txd_oe_o, 1'b1);
         end
      join
      check({f1[9:0], f2[9:0]}, {1'b1, 8'h3C, 1'b0, 1'b1, 8'h5A, 1'b0});
      repeat (16) @(posedge clk_i);
      check({txd_oe_o, txd_o}, 2'b01);
      rd(ADR_STATUS, 8'h60);
      wr(ADR_STATUS, 8'h40);
      rd(ADR_STATUS, 8'h20);
      $display("test tx disable done");
   endtask : t_tx_disable
   task automatic t_rx;
      wr(ADR_FORMAT, 8'h02);
      wr(ADR_CONTROL, 8'h10);
      check(rxd_override_o, 1'b1);
      serial_peer_i.send(9'h1FF, 7, 1'b0, 1'b0, 1'b1);
      rd(ADR_STATUS, 8'hA0);
      rd(ADR_DATA, 8'h7F);
      rd(ADR_STATUS, 8'h20);
      wr(ADR_FORMAT, 8'h2B);
      serial_peer_i.send(9'h081, 8, 1'b1, 1'b1, 1'b0);
      serial_peer_i.send(9'h042, 8, 1'b1, 1'b0, 1'b1);
      rd(ADR_STATUS, 8'hB4);
      rd(ADR_DATA, 8'h81);
      rd(ADR_STATUS, 8'hA0);
      rd(ADR_DATA, 8'h42);
      rd(ADR_STATUS, 8'h20);
      $display("test rx done");
   endtask : t_rx
   // Nine-bit characters: received on the external transfer clock, then sent asynchronously.
   task automatic t_nine;
      wr(ADR_FORMAT, 8'h47);
      serial_peer_i.send_sync(9'h1A5, 9);
      rd(ADR_STATUS, 8'hA0);
      rd(ADR_CONTROL, 8'h12);
      rd(ADR_DATA, 8'hA5);
      rd(ADR_CONTROL, 8'h10);
      wr(ADR_FORMAT, 8'h07);
      wr(ADR_CONTROL, 8'h09);
      fork
         serial_peer_i.recv(10, f1);
         wr(ADR_DATA, 8'h3C);
      join
      check(f1, {2'b11, 8'h3C, 1'b0});
      $display("test nine bit done");
   endtask : t_nine
   task automatic tally_and_finish;
      $display("checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish
   // The ceiling allows over twenty times the expected run of about 1600 cycles.
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 40000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_tx_parity();
      t_tx_disable();
      t_rx();
      t_nine();
      tally_and_finish();
   end
endmodule : uart_core_test
